// ---- src/mec_chan.v ----
// One measurement channel: event decode and its 32-bit counter.
// Assumes synchronised levels and edges, one clock domain.
`timescale 1ns/10ps
`include "mec_defines.vh"
module mec_chan #(
  parameter CNT_W = `MEC_CNT_W
) (
  input  wire                  clk_in,
  input  wire                  rst_b_in,
  input  wire                  run_in,
  input  wire                  start_in,
  input  wire                  sample_in,
  input  wire [`MEC_CFG_W-1:0] cfg_in,
  input  wire                  meas_lvl_in,
  input  wire                  meas_rise_in,
  input  wire                  meas_fall_in,
  input  wire                  qual_lvl_in,
  input  wire                  qual_rise_in,
  input  wire                  qual_fall_in,
  output reg  [CNT_W-1:0]      count_out
);
  wire [1:0] evt  = cfg_in[`MEC_EVT_MSB:`MEC_EVT_LSB];
  wire [1:0] rmod = cfg_in[`MEC_RST_MSB:`MEC_RST_LSB];
  wire [2:0] mode = cfg_in[`MEC_MODE_MSB:`MEC_MODE_LSB];
  wire       meas_edge = meas_rise_in | meas_fall_in;
  wire       differ    = meas_lvl_in ^ qual_lvl_in;
  reg        armed;
  reg        next_armed;
  reg        ev;
  reg        qual_clr;
  reg  [1:0] up_n;
  reg  [1:0] dn_n;
  reg        clr;
  reg  [CNT_W-1:0] next_count;
  always @*
  begin
    ev = 1'b0;
    next_armed = armed;
    qual_clr = 1'b0;
    up_n = 2'h0;
    dn_n = 2'h0;
    case (evt)
      `MEC_EVT_RISE: ev = meas_rise_in;
      `MEC_EVT_FALL: ev = meas_fall_in;
      `MEC_EVT_BOTH: ev = meas_edge;
      default:
      begin
        // Period ends on next start edge
        if (cfg_in[`MEC_CYC_BIT] ? meas_fall_in : meas_rise_in)
        begin
          if (armed)
            ev = 1'b1;
          next_armed = 1'b1;
        end
      end
    endcase
    case (mode)
      `MEC_MODE_STD_QUAL:
        up_n = {1'b0, ev};
      `MEC_MODE_UD_LEVEL:
      begin
        up_n = {1'b0, ev & qual_lvl_in};
        dn_n = {1'b0, ev & ~qual_lvl_in};
      end
      `MEC_MODE_UD_AB:
      begin
        up_n = {1'b0, meas_rise_in};
        dn_n = {1'b0, qual_rise_in};
      end
      `MEC_MODE_X1:
      begin
        up_n = {1'b0, meas_rise_in & differ};
        dn_n = {1'b0, meas_rise_in & ~differ};
      end
      `MEC_MODE_X2:
      begin
        up_n = {1'b0, meas_edge & differ};
        dn_n = {1'b0, meas_edge & ~differ};
      end
      `MEC_MODE_X4:
      begin
        up_n = {1'b0, meas_edge & differ} + {1'b0, (qual_rise_in | qual_fall_in) & ~differ};
        dn_n = {1'b0, meas_edge & ~differ} + {1'b0, (qual_rise_in | qual_fall_in) & differ};
      end
      // Standard: up only, own input only
      default:
        up_n = {1'b0, ev};
    endcase
    // Qualifier edge clear, MEC_MODE_STD_QUAL and MEC_MODE_UD_LEVEL only
    if (rmod == `MEC_RST_QUAL &&
        (mode == `MEC_MODE_STD_QUAL || mode == `MEC_MODE_UD_LEVEL))
      qual_clr = cfg_in[`MEC_QEDGE_BIT] ? qual_fall_in : qual_rise_in;
    if (!run_in)
    begin
      up_n = 2'h0;
      dn_n = 2'h0;
      qual_clr = 1'b0;
    end
    // Per-sample clear; free run clears only at start
    clr = start_in | qual_clr | (sample_in & (rmod == `MEC_RST_SAMPLE));
    // Modulo add: wraps instead of saturating
    next_count = (clr ? {CNT_W{1'b0}} : count_out) + {{(CNT_W-2){1'b0}}, up_n}
                 - {{(CNT_W-2){1'b0}}, dn_n};
    if (start_in)
      next_armed = 1'b0;
  end
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      count_out <= {CNT_W{1'b0}};
      armed     <= 1'b0;
    end
    else
    begin
      count_out <= next_count;
      armed     <= next_armed;
    end
  end
endmodule // mec_chan

// ---- src/mec_defines.vh ----
// Constants of the multichannel event counter: offsets, fields, codes.
// Included by every design file; holds definitions only.
`ifndef MEC_DEFINES_VH
`define MEC_DEFINES_VH
`define MEC_NCH             4
`define MEC_SEL_W           2
`define MEC_ADDR_W          8
`define MEC_DATA_W          32
`define MEC_CNT_W           32
`define MEC_CFG_W           11
// Register pages: address bits [7:4] pick a page, [3:2] a channel
`define MEC_PAGE_MSB        7
`define MEC_PAGE_LSB        4
`define MEC_IDX_MSB         3
`define MEC_IDX_LSB         2
`define MEC_ADDR_CTRL       8'h00
`define MEC_ADDR_STATE_SEL  8'h04
`define MEC_ADDR_SAMPLE_DIV 8'h08
`define MEC_ADDR_STATUS     8'h0C
`define MEC_ADDR_TIMEBASE   8'h10
`define MEC_ADDR_COMBINED   8'h14
`define MEC_PAGE_CFG        4'h2
`define MEC_PAGE_COUNT      4'h3
`define MEC_PAGE_SAMPLE     4'h4
`define MEC_LANE_ALIGN      2'h0
// Control register
`define MEC_CTRL_RUN        0
// Channel configuration fields
`define MEC_EVT_MSB         1
`define MEC_EVT_LSB         0
`define MEC_RST_MSB         3
`define MEC_RST_LSB         2
`define MEC_QSEL_MSB        5
`define MEC_QSEL_LSB        4
`define MEC_QEDGE_BIT       6
`define MEC_CYC_BIT         7
`define MEC_MODE_MSB        10
`define MEC_MODE_LSB        8
// Event codes
`define MEC_EVT_RISE        2'h0
`define MEC_EVT_FALL        2'h1
`define MEC_EVT_BOTH        2'h2
`define MEC_EVT_CYCLE       2'h3
// Counter reset codes
`define MEC_RST_SAMPLE      2'h0
`define MEC_RST_QUAL        2'h1
`define MEC_RST_FREE        2'h2
// Counter modes
`define MEC_MODE_STD        3'h0
`define MEC_MODE_STD_QUAL   3'h1
`define MEC_MODE_UD_LEVEL   3'h2
`define MEC_MODE_UD_AB      3'h3
`define MEC_MODE_X1         3'h4
`define MEC_MODE_X2         3'h5
`define MEC_MODE_X4         3'h6
// Reset values
`define MEC_CFG_RESET       11'h008
`define MEC_STATE_SEL_RESET 4'hF
`define MEC_DIV_RESET       32'h0000_03E8
// Time base
`define MEC_CLK_PERIOD_NS   8
`define MEC_TICK_NS         20
`define MEC_ACC_W           5
`endif

// ---- src/mec_sync.v ----
// Input synchroniser with edge detection for a group of pins.
// Assumes asynchronous pin levels; edges come from the second stage.
`timescale 1ns/10ps
`include "mec_defines.vh"
module mec_sync #(
  parameter WIDTH = `MEC_NCH
) (
  input  wire             clk_in,
  input  wire             rst_b_in,
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] lvl_out,
  output wire [WIDTH-1:0] rise_out,
  output wire [WIDTH-1:0] fall_out
);
  reg [WIDTH-1:0] meta;
  reg [WIDTH-1:0] prev;
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      meta    <= {WIDTH{1'b0}};
      lvl_out <= {WIDTH{1'b0}};
      prev    <= {WIDTH{1'b0}};
    end
    else
    begin
      meta    <= pin_in;
      lvl_out <= meta;
      prev    <= lvl_out;
    end
  end
  assign rise_out = lvl_out & ~prev;
  assign fall_out = ~lvl_out & prev;
endmodule // mec_sync

// ---- src/mec_top.v ----
// Four-channel event counter with sampled state byte and register port.
// Assumes asynchronous sensor pins and a single-cycle register master.
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "mec_defines.vh"
module mec_top #(
  parameter NCH   = `MEC_NCH,
  parameter CNT_W = `MEC_CNT_W
) (
  input  wire                   clk_in,
  input  wire                   rst_b_in,
  input  wire [NCH-1:0]         sensor_in,
  input  wire [`MEC_ADDR_W-1:0] addr_in,
  input  wire [`MEC_DATA_W-1:0] wr_data_in,
  input  wire                   wr_in,
  input  wire                   rd_in,
  output reg  [`MEC_DATA_W-1:0] rd_data_out,
  output reg  [7:0]             combined_state_byte_out,
  output reg                    sample_point_out
);
  localparam [`MEC_ACC_W-1:0] ACC_STEP = `MEC_CLK_PERIOD_NS;
  localparam [`MEC_ACC_W-1:0] ACC_WRAP = `MEC_TICK_NS;

  // Synchronised levels and edges
  wire [NCH-1:0] lvl;
  wire [NCH-1:0] rise;
  wire [NCH-1:0] fall;

  // Software state
  reg                   run;
  reg                   run_q;
  reg  [NCH-1:0]        state_sel;
  reg  [CNT_W-1:0]      sample_div;
  reg  [`MEC_CFG_W-1:0] cfg_mem [0:NCH-1];
  reg  [CNT_W-1:0]      sample_mem [0:NCH-1];

  // Sampling and time base
  reg  [CNT_W-1:0]      div_cnt;
  reg  [CNT_W-1:0]      timebase;
  reg  [`MEC_ACC_W-1:0] acc;
  reg  [`MEC_ACC_W-1:0] next_acc;
  reg                   tick;

  wire [CNT_W-1:0]      count_w [0:NCH-1];
  wire [`MEC_CFG_W*NCH-1:0] eff_cfg;
  wire                  run_start = run & ~run_q;
  wire [`MEC_PAGE_MSB-`MEC_PAGE_LSB:0] page = addr_in[`MEC_PAGE_MSB:`MEC_PAGE_LSB];
  wire [`MEC_SEL_W-1:0] idx = addr_in[`MEC_IDX_MSB:`MEC_IDX_LSB];
  wire                  aligned = (addr_in[1:0] == `MEC_LANE_ALIGN);
  reg  [`MEC_DATA_W-1:0] next_rd_data;

  // Pins pass two flops before any use
  mec_sync #(
    .WIDTH (NCH)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .pin_in   (sensor_in),
    .lvl_out  (lvl),
    .rise_out (rise),
    .fall_out (fall)
  );

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : g_chan
      wire [`MEC_CFG_W-1:0] raw = cfg_mem[g];
      wire [2:0]            md  = raw[`MEC_MODE_MSB:`MEC_MODE_LSB];
      wire [`MEC_SEL_W-1:0] qs  = raw[`MEC_QSEL_MSB:`MEC_QSEL_LSB];
      wire                  xq  = (md == `MEC_MODE_X1) || (md == `MEC_MODE_X2) ||
                                  (md == `MEC_MODE_X4);
      // Quadrature: reset only per sample or free
      wire [1:0]            rm  = (xq && raw[`MEC_RST_MSB:`MEC_RST_LSB] == `MEC_RST_QUAL) ?
                                  `MEC_RST_FREE : raw[`MEC_RST_MSB:`MEC_RST_LSB];
      assign eff_cfg[g*`MEC_CFG_W +: `MEC_CFG_W] =
        {md, raw[`MEC_CYC_BIT:`MEC_QSEL_LSB], rm, raw[`MEC_EVT_MSB:`MEC_EVT_LSB]};
      mec_chan #(
        .CNT_W (CNT_W)
      ) u_chan (
        .clk_in       (clk_in),
        .rst_b_in     (rst_b_in),
        .run_in       (run),
        .start_in     (run_start),
        .sample_in    (sample_point_out),
        .cfg_in       (eff_cfg[g*`MEC_CFG_W +: `MEC_CFG_W]),
        .meas_lvl_in  (lvl[g]),
        .meas_rise_in (rise[g]),
        .meas_fall_in (fall[g]),
        .qual_lvl_in  (lvl[qs]),
        .qual_rise_in (rise[qs]),
        .qual_fall_in (fall[qs]),
        .count_out    (count_w[g])
      );
    end
  endgenerate

  // Register writes; read-only pages ignore writes
  integer i;
  integer j;
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      run        <= 1'b0;
      state_sel  <= `MEC_STATE_SEL_RESET;
      sample_div <= `MEC_DIV_RESET;
      for (i = 0; i < NCH; i = i + 1)
        cfg_mem[i] <= `MEC_CFG_RESET;
    end
    else if (wr_in && aligned)
    begin
      if (addr_in == `MEC_ADDR_CTRL)
        run <= wr_data_in[`MEC_CTRL_RUN];
      else if (addr_in == `MEC_ADDR_STATE_SEL)
        state_sel <= wr_data_in[NCH-1:0];
      else if (addr_in == `MEC_ADDR_SAMPLE_DIV)
        sample_div <= wr_data_in[CNT_W-1:0];
      else if (page == `MEC_PAGE_CFG)
        cfg_mem[idx] <= wr_data_in[`MEC_CFG_W-1:0];
    end
  end

  // Sampling point generator; a zero divisor acts as one
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      run_q            <= 1'b0;
      div_cnt          <= {CNT_W{1'b0}};
      sample_point_out <= 1'b0;
    end
    else
    begin
      run_q <= run;
      if (!run || run_start)
      begin
        div_cnt          <= {CNT_W{1'b0}};
        sample_point_out <= 1'b0;
      end
      else if (div_cnt + {{(CNT_W-1){1'b0}}, 1'b1} >= sample_div)
      begin
        div_cnt          <= {CNT_W{1'b0}};
        sample_point_out <= 1'b1;
      end
      else
      begin
        div_cnt          <= div_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
        sample_point_out <= 1'b0;
      end
    end
  end

  // Capture results at each sampling point
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      combined_state_byte_out <= 8'h00;
      for (j = 0; j < NCH; j = j + 1)
        sample_mem[j] <= {CNT_W{1'b0}};
    end
    else if (sample_point_out)
    begin
      // Masked levels, channel 1 in bit 0
      combined_state_byte_out <= {{(8-NCH){1'b0}}, lvl & state_sel};
      for (j = 0; j < NCH; j = j + 1)
        sample_mem[j] <= count_w[j];
    end
  end

  // Fractional accumulator: 8 ns steps average one tick per 20 ns
  always @*
  begin
    if (acc + ACC_STEP >= ACC_WRAP)
      next_acc = acc + ACC_STEP - ACC_WRAP;
    else
      next_acc = acc + ACC_STEP;
  end

  // Time base counts 20 ns units, wraps
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      acc      <= {`MEC_ACC_W{1'b0}};
      tick     <= 1'b0;
      timebase <= {CNT_W{1'b0}};
    end
    else
    begin
      acc  <= next_acc;
      tick <= (acc + ACC_STEP >= ACC_WRAP);
      if (run_start)
        timebase <= {CNT_W{1'b0}};
      else if (run && tick)
        timebase <= timebase + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Read decode; unmapped or misaligned reads return zero
  always @*
  begin
    next_rd_data = {`MEC_DATA_W{1'b0}};
    if (!aligned)
      next_rd_data = {`MEC_DATA_W{1'b0}};
    else if (addr_in == `MEC_ADDR_CTRL)
      next_rd_data[`MEC_CTRL_RUN] = run;
    else if (addr_in == `MEC_ADDR_STATE_SEL)
      next_rd_data[NCH-1:0] = state_sel;
    else if (addr_in == `MEC_ADDR_SAMPLE_DIV)
      next_rd_data = sample_div;
    else if (addr_in == `MEC_ADDR_STATUS)
      next_rd_data[NCH-1:0] = lvl;
    else if (addr_in == `MEC_ADDR_TIMEBASE)
      next_rd_data = timebase;
    else if (addr_in == `MEC_ADDR_COMBINED)
      next_rd_data[7:0] = combined_state_byte_out;
    else if (page == `MEC_PAGE_CFG)
      next_rd_data[`MEC_CFG_W-1:0] = cfg_mem[idx];
    else if (page == `MEC_PAGE_COUNT)
      next_rd_data = count_w[idx];
    else if (page == `MEC_PAGE_SAMPLE)
      next_rd_data = sample_mem[idx];
  end

  // Data stands only in the cycle after the strobe
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      rd_data_out <= {`MEC_DATA_W{1'b0}};
    else if (rd_in)
      rd_data_out <= next_rd_data;
    else
      rd_data_out <= {`MEC_DATA_W{1'b0}};
  end
endmodule // mec_top

// ---- verif/mec_sensor_model.sv ----
// Four push-pull digital sensor lines.
// Assumes tasks are called from one bench process at a time.
`timescale 1ns/10ps
module mec_sensor_model (
  input  wire       clk_in,
  output reg  [3:0] sensor_out
);
  initial sensor_out = 4'h0;

  task set_lvl(input [3:0] lvl);
  begin
    @(posedge clk_in);
    sensor_out <= lvl;
  end
  endtask

  // len cycles active, len cycles inactive
  // Phase length sets a prompt (1) or slow sensor
  task pulse(input [3:0] mask, input integer n, input integer len);
    integer i;
  begin
    for (i = 0; i < n; i = i + 1)
    begin
      @(posedge clk_in);
      sensor_out <= sensor_out | mask;
      repeat (len) @(posedge clk_in);
      sensor_out <= sensor_out & ~mask;
      repeat (len - 1) @(posedge clk_in);
    end
  end
  endtask
endmodule // mec_sensor_model

// ---- verif/mec_top_properties.sv ----
// Port checker for mec_top, bound into every instance.
// Assumes the single-cycle register master and map of mec_top.
`timescale 1ns/10ps
module mec_top_checker #(
  parameter NCH = 4
) (
  input wire           clk_in,
  input wire           rst_b_in,
  input wire [NCH-1:0] sensor_in,
  input wire [7:0]     addr_in,
  input wire [31:0]    wr_data_in,
  input wire           wr_in,
  input wire           rd_in,
  input wire [31:0]    rd_data_out,
  input wire [7:0]     combined_state_byte_out,
  input wire           sample_point_out
);
  // Shadows of the control, state select and sample divider registers
  reg         run_q;
  reg  [3:0]  sel_q;
  reg  [31:0] div_q;
  reg  [31:0] gap;
  reg         seen;
  wire        wr_div  = wr_in && addr_in == 8'h08;
  wire [31:0] eff_div = (div_q == 32'h0) ? 32'h1 : div_q;

  always @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      run_q <= 1'b0;
      sel_q <= 4'hF;
      div_q <= 32'h3E8;
      gap   <= 32'h0;
      seen  <= 1'b0;
    end
    else
    begin
      if (wr_in && addr_in == 8'h00)
        run_q <= wr_data_in[0];
      if (wr_in && addr_in == 8'h04)
        sel_q <= wr_data_in[3:0];
      if (wr_div)
        div_q <= wr_data_in;
      gap <= sample_point_out ? 32'h0 : gap + 32'h1;
      // First interval after a restart or divider change is not known
      seen <= (run_q && !wr_div) ? (seen | sample_point_out) : 1'b0;
    end

  default clocking dcb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  chk_rd_answer_only:
    assert property (rd_data_out != 32'h0 |-> $past(rd_in))
    else $error("read data seen without a read strobe");
  chk_comb_high_zero:
    assert property (combined_state_byte_out[7:4] == 4'h0)
    else $error("combined byte upper half not zero");
  chk_comb_on_sample:
    assert property ($changed(combined_state_byte_out) |-> $past(sample_point_out))
    else $error("combined byte changed away from a sample");
  chk_comb_unsel_zero:
    assert property ($past(sample_point_out) |->
      (combined_state_byte_out[3:0] & ~(sel_q | $past(sel_q) | $past(sel_q, 2))) == 4'h0)
    else $error("unselected channel bit set in combined byte");
  chk_ctrl_read_back:
    assert property ($past(rd_in && addr_in == 8'h00) |-> rd_data_out == {31'h0, run_q})
    else $error("control read differs from last write");
  chk_sel_read_back:
    assert property ($past(rd_in && addr_in == 8'h04) |-> rd_data_out == {28'h0, sel_q})
    else $error("state select read differs from last write");
  chk_bad_addr_zero:
    assert property ($past(rd_in && (addr_in[1:0] != 2'h0 || addr_in[7:4] > 4'h4
      || addr_in[7:3] == 5'h03)) |-> rd_data_out == 32'h0)
    else $error("unmapped read returned data");
  chk_sample_period:
    assert property (sample_point_out && seen |-> gap == eff_div - 32'h1)
    else $error("sample spacing differs from divider");

  cover property (sample_point_out && seen);
  cover property ($past(rd_in) && rd_data_out != 32'h0);
  cover property ($changed(combined_state_byte_out));
endmodule // mec_top_checker

bind mec_top mec_top_checker #(.NCH(NCH)) u_mec_chk (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .sensor_in(sensor_in), .addr_in(addr_in),
  .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
  .combined_state_byte_out(combined_state_byte_out), .sample_point_out(sample_point_out)
);

// ---- verif/tb_multichannel_event_counter.sv ----
// Bench for mec_top: register tasks plus a sensor model.
// Assumes read data one cycle after the strobe and no wait states.
`timescale 1ns/10ps
module tb_multichannel_event_counter;
  reg         clk_in;
  reg         rst_b_in;
  reg  [7:0]  addr_in;
  reg  [31:0] wr_data_in;
  reg         wr_in;
  reg         rd_in;
  reg  [7:0]  k;
  reg  [31:0] kept;
  wire [3:0]  sensor;
  wire [31:0] rd_data_out;
  wire [7:0]  comb;
  wire        sample_pt;
  integer     error_cnt;
  integer     check_count;

  mec_top u_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .sensor_in(sensor), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
    .combined_state_byte_out(comb), .sample_point_out(sample_pt)
  );
  mec_sensor_model u_sens (
    .clk_in(clk_in), .sensor_out(sensor)
  );

  always #4 clk_in = ~clk_in;

  task give_verdict;
  begin
    if (error_cnt == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask

  task chk32(input [8*10:1] what, input [31:0] exp, input [31:0] got);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
    end
  end
  endtask

  task wr(input [7:0] a, input [31:0] d);
  begin
    @(posedge clk_in);
    wr_in      <= 1'b1;
    addr_in    <= a;
    wr_data_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  end
  endtask

  task rd(input [7:0] a, input [31:0] exp);
  begin
    @(posedge clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk32("reg read", exp, rd_data_out);
  end
  endtask

  // Keeps read data for a later relative compare
  task rd_keep(input [7:0] a);
  begin
    @(posedge clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    kept = rd_data_out;
  end
  endtask

  task wait_sample;
    integer n;
  begin
    n = 0;
    @(posedge clk_in);
    #1;
    while (sample_pt !== 1'b1 && n < 3000)
    begin
      @(posedge clk_in);
      #1;
      n = n + 1;
    end
    if (n >= 3000)
    begin
      chk32("sample", 32'h1, 32'h0);
      give_verdict;
    end
  end
  endtask

  // Combined byte lands one cycle after the sample point
  task comb_chk(input [7:0] exp);
  begin
    wait_sample;
    wait_sample;
    @(posedge clk_in);
    #1;
    chk32("combined", {24'h0, exp}, {24'h0, comb});
  end
  endtask

  initial
  begin
    clk_in      = 1'b0;
    rst_b_in    = 1'b0;
    addr_in     = 8'h00;
    wr_data_in  = 32'h0;
    wr_in       = 1'b0;
    rd_in       = 1'b0;
    error_cnt   = 0;
    check_count = 0;
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'hF);
    rd(8'h08, 32'h3E8);
    for (k = 8'h20; k < 8'h30; k = k + 8'h04)
      rd(k, 32'h8);
    rd(8'h18, 32'h0);
    rd(8'h01, 32'h0);
    wr(8'h08, 32'h8);
    wr(8'h20, 32'h008);
    wr(8'h24, 32'h009);
    wr(8'h28, 32'h00A);
    wr(8'h2C, 32'h00B);
    wr(8'h00, 32'h1);
    rd(8'h00, 32'h1);
    u_sens.pulse(4'hF, 3, 2);
    u_sens.pulse(4'h1, 2, 1);
    repeat (8) @(posedge clk_in);
    rd(8'h30, 32'h5);
    rd(8'h34, 32'h3);
    rd(8'h38, 32'h6);
    rd(8'h3C, 32'h2);
    wr(8'h30, 32'h55);
    rd(8'h30, 32'h5);
    wr(8'h00, 32'h0);
    wr(8'h20, 32'h000);
    wr(8'h08, 32'h40);
    wr(8'h00, 32'h1);
    wait_sample;
    u_sens.pulse(4'h1, 2, 2);
    wait_sample;
    rd(8'h40, 32'h2);
    wait_sample;
    rd(8'h40, 32'h0);
    wr(8'h24, 32'h124);
    u_sens.pulse(4'h2, 3, 1);
    repeat (6) @(posedge clk_in);
    rd(8'h34, 32'h3);
    u_sens.pulse(4'h6, 1, 2);
    repeat (6) @(posedge clk_in);
    rd(8'h34, 32'h1);
    wr(8'h24, 32'h164);
    u_sens.pulse(4'h6, 1, 2);
    repeat (6) @(posedge clk_in);
    rd(8'h34, 32'h0);
    u_sens.set_lvl(4'hF);
    wr(8'h04, 32'h5);
    comb_chk(8'h05);
    rd(8'h0C, 32'hF);
    wr(8'h04, 32'hF);
    u_sens.set_lvl(4'hA);
    comb_chk(8'h0A);
    u_sens.set_lvl(4'h0);
    wr(8'h2C, 32'h208);
    repeat (6) @(posedge clk_in);
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h1);
    u_sens.pulse(4'h8, 2, 1);
    repeat (6) @(posedge clk_in);
    rd(8'h3C, 32'hFFFF_FFFE);
    u_sens.set_lvl(4'h1);
    repeat (4) @(posedge clk_in);
    u_sens.pulse(4'h8, 1, 1);
    repeat (6) @(posedge clk_in);
    rd(8'h3C, 32'hFFFF_FFFF);
    // A/B mode on channel 3 against channel 4; channel 4 wraps to zero
    wr(8'h28, 32'h338);
    u_sens.pulse(4'h4, 3, 1);
    u_sens.pulse(4'h8, 1, 1);
    repeat (6) @(posedge clk_in);
    rd(8'h38, 32'h2);
    rd(8'h3C, 32'h0);
    // X1 on channel 2; its requested qualifier clear must stay inert
    wr(8'h24, 32'h424);
    u_sens.pulse(4'h2, 2, 1);
    u_sens.set_lvl(4'h5);
    u_sens.pulse(4'h2, 1, 1);
    repeat (6) @(posedge clk_in);
    rd(8'h34, 32'h1);
    // Ten cycles of 8 ns hold exactly four 20 ns units
    rd_keep(8'h10);
    repeat (8) @(posedge clk_in);
    rd(8'h10, kept + 32'h4);
    give_verdict;
  end
endmodule // tb_multichannel_event_counter
